//--- verilog/cbts_bit_timing.sv
// Bit timing and synchronisation logic with its APB register slave.
`timescale 1ns/1ps
module cbts_bit_timing (
  input wire logic pclk, // System clock, 125 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write when high.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic can_rx, // Received bus level from the transceiver.
  output logic rx_bit, // Bus level taken at the last sample point.
  output cbts_pkg::cbts_event_t events // Registered event pulses.
);
  import cbts_pkg::*;
  `include "cbts_consts.svh"

  // ------------------------------------------------------------------
  // Address decoding
  // ------------------------------------------------------------------
  // Matches an aligned word offset.
  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offs);
    addr_hit = (addr[11:2] == offs[11:2]);
  endfunction

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  logic [31:0] cfg_q; // Timing configuration word.
  logic [31:0] cfg_d; // Next configuration word.
  logic enable_q; // Sequencer runs while high.
  logic enable_d; // Next enable.
  logic harm_q; // Hard synchronisation armed for the next frame.
  logic harm_d; // Next armed flag.
  logic resync_en_q; // Re-synchronisation allowed inside a frame.
  logic resync_en_d; // Next re-synchronisation enable.
  logic pready_q; // Registered ready.
  logic pready_d; // Next ready.
  logic [31:0] prdata_q; // Registered read data.
  logic [31:0] prdata_d; // Next read data.
  logic pslverr_q; // Registered error.
  logic pslverr_d; // Next error.
  logic wr_fire; // Write completes this edge.
  logic mapped; // Address names a register.
  logic [31:0] status_word; // Assembled status view.
  logic hard_now; // Sequencer performs a hard sync this cycle.
  cbts_cfg_t cfg; // Configuration fields.

  // Sequencer state, declared here for the status view.
  cbts_state_t state_q; // Current segment.
  cbts_state_t state_d; // Next segment.
  logic sample_q; // Level taken at the last sample point.
  logic sample_d; // Next sampled level.
  logic done_q; // A synchronisation occurred since the last sample point.
  logic done_d; // Next done flag.
  logic [7:0] hcnt_q; // Hard synchronisations performed.
  logic [7:0] hcnt_d; // Next hard count.
  logic [7:0] rcnt_q; // Re-synchronisations performed.
  logic [7:0] rcnt_d; // Next re-sync count.

  assign cfg = cbts_cfg_t'({cfg_q[`CBTS_CFG_MJW_MSB:`CBTS_CFG_MJW_LSB],
                            cfg_q[`CBTS_CFG_POST_MSB:`CBTS_CFG_POST_LSB],
                            cfg_q[`CBTS_CFG_PRE_MSB:`CBTS_CFG_PRE_LSB],
                            cfg_q[`CBTS_CFG_PROP_MSB:`CBTS_CFG_PROP_LSB],
                            cfg_q[`CBTS_CFG_PRESC_MSB:`CBTS_CFG_PRESC_LSB]});

  // Status word shows the sequencer's state and the hard synchronisation armed flag.
  always_comb begin
    status_word = 32'h00000000;
    status_word[`CBTS_ST_LEVEL_BIT] = sample_q;
    status_word[`CBTS_ST_HARM_BIT] = harm_q;
    status_word[`CBTS_ST_DONE_BIT] = done_q;
    status_word[`CBTS_ST_STATE_MSB:`CBTS_ST_STATE_LSB] = state_q;
    status_word[`CBTS_ST_HCNT_MSB:`CBTS_ST_HCNT_LSB] = hcnt_q;
    status_word[`CBTS_ST_RCNT_MSB:`CBTS_ST_RCNT_LSB] = rcnt_q;
  end

  // One wait state: ready rises in the second access cycle.
  always_comb begin
    mapped = addr_hit(paddr, `CBTS_CFG_OFFSET) || addr_hit(paddr, `CBTS_CTRL_OFFSET) ||
             addr_hit(paddr, `CBTS_STATUS_OFFSET);
    wr_fire = psel && penable && pready_q && pwrite && mapped;
    pready_d = psel && penable && !pready_q;
    pslverr_d = pready_d && !mapped;
    prdata_d = 32'h00000000;
    if (pready_d && !pwrite) begin
      if (addr_hit(paddr, `CBTS_CFG_OFFSET)) begin
        prdata_d = cfg_q;
      end else if (addr_hit(paddr, `CBTS_CTRL_OFFSET)) begin
        prdata_d = {29'h00000000, resync_en_q, harm_q, enable_q};
      end else if (addr_hit(paddr, `CBTS_STATUS_OFFSET)) begin
        prdata_d = status_word;
      end
    end
    cfg_d = cfg_q;
    enable_d = enable_q;
    resync_en_d = resync_en_q;
    harm_d = hard_now ? 1'b0 : harm_q;
    if (wr_fire && addr_hit(paddr, `CBTS_CFG_OFFSET)) begin
      cfg_d = pwdata & `CBTS_CFG_WMASK;
    end
    if (wr_fire && addr_hit(paddr, `CBTS_CTRL_OFFSET)) begin
      enable_d = pwdata[`CBTS_CTRL_ENABLE_BIT];
      resync_en_d = pwdata[`CBTS_CTRL_RESYNC_BIT];
      harm_d = pwdata[`CBTS_CTRL_HARM_BIT]; // Software arming wins over the hardware clear.
    end
  end

  // Register file and bus answer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `CBTS_CFG_RESET;
      enable_q <= 1'b0;
      harm_q <= 1'b0;
      resync_en_q <= 1'b0;
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      enable_q <= enable_d;
      harm_q <= harm_d;
      resync_en_q <= resync_en_d;
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ------------------------------------------------------------------
  // Input path and quantum clock
  // ------------------------------------------------------------------
  logic rx_level; // Synchronised bus level.
  logic quantum_tick; // One pulse per time quantum.

  // Synchroniser keeps the pin out of the sequencer's decisions until stable.
  cbts_rx_sync u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .rx_pin(can_rx),
    .rx_level(rx_level)
  );

  // Prescaler derives the time quantum from the system clock.
  cbts_quantum_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(enable_q),
    .divide_m1(cfg.quantum_prescaler_m1),
    .quantum_tick(quantum_tick)
  );

  // ------------------------------------------------------------------
  // Bit sequencer
  // ------------------------------------------------------------------
  logic [3:0] cnt_q; // Quanta elapsed in the current segment.
  logic [3:0] cnt_d; // Next quantum count.
  logic [3:0] pre_len_q; // Pre-sample buffer length for this bit.
  logic [3:0] pre_len_d; // Next pre-sample length.
  logic [3:0] post_len_q; // Post-sample buffer length for this bit.
  logic [3:0] post_len_d; // Next post-sample length.
  logic skip_q; // Next bit omits its alignment slot.
  logic skip_d; // Next skip flag.
  logic rx_bit_q; // Registered sampled bit output.
  logic rx_bit_d; // Next sampled bit output.
  cbts_event_t evt_q; // Registered event pulses.
  cbts_event_t evt_d; // Next event pulses.
  logic [3:0] prop_len; // Delay compensation length in quanta.
  logic [3:0] pre_nom; // Nominal pre-sample length.
  logic [3:0] post_nom; // Nominal post-sample length.
  logic [4:0] jump; // Maximum jump width in quanta.
  logic [4:0] err; // Magnitude of the phase error.
  logic [4:0] step; // Correction applied, error limited by the jump width.
  logic edge_seen; // Qualifying falling bus edge this quantum.
  logic [3:0] pre_eff; // Pre-sample length used for this quantum's end test.
  logic [3:0] post_eff; // Post-sample length used for this quantum's end test.

  // Nominal segment lengths, each field holding its value minus one.
  always_comb begin
    prop_len = {1'b0, cfg.prop_m1} + 4'h1;
    pre_nom = {1'b0, cfg.pre_sample_buffer_m1} + 4'h1;
    post_nom = {1'b0, cfg.post_sample_buffer_m1} + 4'h1;
    jump = {3'h0, cfg.max_jump_width_m1} + 5'h01;
  end

  // Per-quantum sequencing, edge qualification and phase correction.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pre_len_d = pre_len_q;
    post_len_d = post_len_q;
    skip_d = skip_q;
    sample_d = sample_q;
    done_d = done_q;
    hcnt_d = hcnt_q;
    rcnt_d = rcnt_q;
    rx_bit_d = rx_bit_q;
    evt_d = '0;
    hard_now = 1'b0;
    err = 5'h00;
    step = 5'h00;
    pre_eff = pre_len_q;
    post_eff = post_len_q;
    // A falling edge counts only against a recessive last sample.
    edge_seen = quantum_tick && (sample_q == `CBTS_RECESSIVE) &&
                (rx_level == `CBTS_DOMINANT) && !done_q &&
                (harm_q || resync_en_q);
    if (!enable_q) begin
      state_d = CBTS_ALIGN; // Idle with nominal lengths.
      cnt_d = 4'h0;
      pre_len_d = pre_nom;
      post_len_d = post_nom;
      skip_d = 1'b0;
      sample_d = `CBTS_RECESSIVE;
      done_d = 1'b0;
    end else if (edge_seen && harm_q) begin
      // This quantum becomes the alignment slot; the bit resumes after it.
      hard_now = 1'b1;
      state_d = CBTS_PROP;
      cnt_d = 4'h0;
      pre_len_d = pre_nom;
      post_len_d = post_nom;
      skip_d = 1'b0;
      done_d = 1'b1;
      hcnt_d = hcnt_q + 8'h01;
      evt_d.hard_sync = 1'b1;
      evt_d.bit_start = 1'b1;
    end else if (quantum_tick) begin
      case (state_q)
        CBTS_ALIGN: begin
          if (edge_seen) begin
            done_d = 1'b1;
          end
          state_d = CBTS_PROP;
          cnt_d = 4'h0;
        end
        CBTS_PROP: begin
          if (edge_seen) begin
            err = {1'b0, cnt_q} + 5'h01;
            step = (err < jump) ? err : jump;
            pre_len_d = pre_len_q + step[3:0];
            done_d = 1'b1;
            rcnt_d = rcnt_q + 8'h01;
            evt_d.resync = 1'b1;
          end
          if (cnt_q == prop_len - 4'h1) begin
            state_d = CBTS_PRE;
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        CBTS_PRE: begin
          if (edge_seen) begin
            err = {1'b0, prop_len} + {1'b0, cnt_q} + 5'h01;
            step = (err < jump) ? err : jump;
            pre_eff = pre_len_q + step[3:0];
            pre_len_d = pre_eff;
            done_d = 1'b1;
            rcnt_d = rcnt_q + 8'h01;
            evt_d.resync = 1'b1;
          end
          if (cnt_q == pre_eff - 4'h1) begin
            // Sample point: one sample per bit, re-arming synchronisation.
            sample_d = rx_level;
            rx_bit_d = rx_level;
            done_d = 1'b0;
            post_len_d = post_nom;
            evt_d.sample_point = 1'b1;
            state_d = CBTS_POST;
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        CBTS_POST: begin
          if (edge_seen) begin
            err = {1'b0, post_len_q} - {1'b0, cnt_q};
            done_d = 1'b1;
            rcnt_d = rcnt_q + 8'h01;
            evt_d.resync = 1'b1;
            skip_d = 1'b1;
            if (err <= jump) begin
              post_eff = cnt_q + 4'h1;
            end else begin
              post_eff = post_len_q - jump[3:0] + 4'h1;
            end
            post_len_d = post_eff;
          end
          if (cnt_q == post_eff - 4'h1) begin
            pre_len_d = pre_nom;
            post_len_d = post_nom;
            cnt_d = 4'h0;
            evt_d.bit_start = skip_d; // Pulses when the next bit begins now.
            state_d = skip_d ? CBTS_PROP : CBTS_ALIGN;
            skip_d = 1'b0; // The skip is consumed here and lasts one bit only.
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end
        default: begin
          state_d = CBTS_ALIGN;
          cnt_d = 4'h0;
        end
      endcase
      if (state_q == CBTS_ALIGN) begin
        evt_d.bit_start = 1'b1;
      end
    end
  end

  // Sequencer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CBTS_ALIGN;
      cnt_q <= 4'h0;
      pre_len_q <= 4'h1;
      post_len_q <= 4'h1;
      skip_q <= 1'b0;
      sample_q <= `CBTS_RECESSIVE;
      done_q <= 1'b0;
      hcnt_q <= 8'h00;
      rcnt_q <= 8'h00;
      rx_bit_q <= `CBTS_RECESSIVE;
      evt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pre_len_q <= pre_len_d;
      post_len_q <= post_len_d;
      skip_q <= skip_d;
      sample_q <= sample_d;
      done_q <= done_d;
      hcnt_q <= hcnt_d;
      rcnt_q <= rcnt_d;
      rx_bit_q <= rx_bit_d;
      evt_q <= evt_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_bit = rx_bit_q;
  assign events = evt_q;
endmodule // cbts_bit_timing

//--- verilog/cbts_consts.svh
// Register map, field positions and reset values of the bit timing block.
`ifndef CBTS_CONSTS_SVH
`define CBTS_CONSTS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define CBTS_CFG_OFFSET 12'h000
`define CBTS_CTRL_OFFSET 12'h004
`define CBTS_STATUS_OFFSET 12'h008

// ------------------------------------------------------------------
// Configuration register fields, each holding its value minus one
// ------------------------------------------------------------------
`define CBTS_CFG_PRESC_MSB 4
`define CBTS_CFG_PRESC_LSB 0
`define CBTS_CFG_PROP_MSB 10
`define CBTS_CFG_PROP_LSB 8
`define CBTS_CFG_PRE_MSB 14
`define CBTS_CFG_PRE_LSB 12
`define CBTS_CFG_POST_MSB 18
`define CBTS_CFG_POST_LSB 16
`define CBTS_CFG_MJW_MSB 21
`define CBTS_CFG_MJW_LSB 20
`define CBTS_CFG_WMASK 32'h0037771F
`define CBTS_CFG_RESET 32'h00033000

// ------------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------------
`define CBTS_CTRL_ENABLE_BIT 0
`define CBTS_CTRL_HARM_BIT 1
`define CBTS_CTRL_RESYNC_BIT 2

// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define CBTS_ST_LEVEL_BIT 0
`define CBTS_ST_HARM_BIT 1
`define CBTS_ST_DONE_BIT 2
`define CBTS_ST_STATE_MSB 7
`define CBTS_ST_STATE_LSB 4
`define CBTS_ST_HCNT_MSB 15
`define CBTS_ST_HCNT_LSB 8
`define CBTS_ST_RCNT_MSB 23
`define CBTS_ST_RCNT_LSB 16

// ------------------------------------------------------------------
// Fixed levels and lengths
// ------------------------------------------------------------------
`define CBTS_RECESSIVE 1'b1
`define CBTS_DOMINANT 1'b0
`define CBTS_ALIGN_SLOT_LEN 4'h1

`endif

//--- verilog/cbts_pkg.sv
// Types shared by the bit timing block.
package cbts_pkg;

  // One-hot states of the per-quantum bit sequencer.
  typedef enum logic [3:0] {
    CBTS_ALIGN = 4'h1,
    CBTS_PROP = 4'h2,
    CBTS_PRE = 4'h4,
    CBTS_POST = 4'h8
  } cbts_state_t;

  // Decoded timing configuration, each field holding value minus one.
  typedef struct packed {
    logic [1:0] max_jump_width_m1;
    logic [2:0] post_sample_buffer_m1;
    logic [2:0] pre_sample_buffer_m1;
    logic [2:0] prop_m1;
    logic [4:0] quantum_prescaler_m1;
  } cbts_cfg_t;

  // Event pulses handed to the bit-stream logic.
  typedef struct packed {
    logic bit_start;
    logic sample_point;
    logic hard_sync;
    logic resync;
  } cbts_event_t;

endpackage

//--- verilog/cbts_rx_sync.sv
// Two-stage synchroniser for the received bus level.
`timescale 1ns/1ps
module cbts_rx_sync (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic rx_pin, // Raw bus level from the transceiver.
  output logic rx_level // Synchronised bus level.
);
  import cbts_pkg::*;
  `include "cbts_consts.svh"

  // ------------------------------------------------------------------
  // Synchroniser stages
  // ------------------------------------------------------------------
  logic meta_q; // First stage, read only by the second.
  logic meta_d; // Next value of the first stage.
  logic level_q; // Second stage.
  logic level_d; // Next value of the second stage.

  // Next values simply shift the pin through.
  always_comb begin
    meta_d = rx_pin;
    level_d = meta_q;
  end

  // Both stages idle at the recessive level so reset makes no edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= `CBTS_RECESSIVE;
      level_q <= `CBTS_RECESSIVE;
    end else begin
      meta_q <= meta_d;
      level_q <= level_d;
    end
  end

  assign rx_level = level_q;
endmodule // cbts_rx_sync

//--- verilog/cbts_quantum_prescaler.sv
// Divider that marks one system clock in each time quantum.
`timescale 1ns/1ps
module cbts_quantum_prescaler (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic run, // Counts while high, holds at zero otherwise.
  input wire logic [4:0] divide_m1, // Prescaler value minus one.
  output logic quantum_tick // One-cycle pulse per time quantum.
);
  import cbts_pkg::*;

  // ------------------------------------------------------------------
  // Divider counter
  // ------------------------------------------------------------------
  logic [4:0] count_q; // Clocks elapsed in the current quantum.
  logic [4:0] count_d; // Next count.
  logic tick_q; // Registered quantum pulse.
  logic tick_d; // Next pulse value.

  // Wrap at the programmed value, giving one to thirty-two clocks a quantum.
  always_comb begin
    count_d = count_q;
    tick_d = 1'b0;
    if (!run) begin
      count_d = 5'h00; // Stopped divider restarts cleanly.
    end else if (count_q >= divide_m1) begin
      count_d = 5'h00;
      tick_d = 1'b1;
    end else begin
      count_d = count_q + 5'h01;
    end
  end

  // Register the counter and the pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign quantum_tick = tick_q;
endmodule // cbts_quantum_prescaler

//--- dv/cbts_bus_node.sv
// Behavioural model of the other nodes that drive the received bus level.
`timescale 1ns/1ps
module cbts_bus_node (
  input wire logic pclk, // Clock that paces the bus timing.
  output logic can_rx // Bus level seen by the block.
);
  // The idle bus is recessive.
  initial can_rx = 1'b1;
  // Drives one level for a number of clocks, changing just after an edge.
  task automatic drive(input logic lvl, input int clocks);
    @(posedge pclk);
    can_rx <= lvl;
    repeat (clocks - 1) @(posedge pclk);
  endtask
endmodule // cbts_bus_node

//--- dv/cbts_bit_timing_properties.sv
// Concurrent checks on the ports of the bit timing block.
`timescale 1ns/1ps
module cbts_bit_timing_properties (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Write.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic can_rx, // Bus pin.
  input wire logic rx_bit, // Sampled level.
  input wire cbts_pkg::cbts_event_t events // Event pulses.
);
  import cbts_pkg::*;
  logic [2:0] ctrl_q; // Shadow of the control bits.
  logic synced_q; // A sync has happened since the last sample.
  wire wr_ctrl = psel && penable && pready && pwrite && paddr == 12'h004;
  wire sync = events.hard_sync || events.resync;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Tracks control writes and the window between two sample points.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      synced_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= pwdata[2:0];
      else if (events.hard_sync) ctrl_q[1] <= 1'b0;
      if (events.sample_point) synced_q <= 1'b0;
      else if (sync) synced_q <= 1'b1;
    end
  end
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
    else $error("ready not after one wait state");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_edge_dominant: assert property (sync |-> !$past(can_rx, 2) || !$past(can_rx, 3) || !$past(can_rx, 4))
    else $error("sync without dominant level");
  chk_prev_recessive: assert property (sync |-> $past(rx_bit))
    else $error("sync after dominant sample");
  chk_one_sync: assert property (sync |-> !synced_q) else $error("second sync");
  chk_hard_armed: assert property (events.hard_sync |-> ctrl_q[1] && ctrl_q[0])
    else $error("hard sync not armed");
  chk_resync_on: assert property (events.resync |-> ctrl_q[2] && ctrl_q[0])
    else $error("resync while disabled");
  chk_sync_kind: assert property (!(events.hard_sync && events.resync))
    else $error("both sync kinds");
  chk_single_sample: assert property ($changed(rx_bit) |-> events.sample_point || $past(events.sample_point))
    else $error("level changed off sample point");
  chk_bit_order: assert property (events.bit_start |=> !events.sample_point)
    else $error("sample right after bit start");
  cov_hard: cover property (events.hard_sync);
  cov_resync: cover property (events.resync);
  cov_err: cover property (pslverr);
endmodule // cbts_bit_timing_properties

bind cbts_bit_timing cbts_bit_timing_properties i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .rx_bit(rx_bit),
  .events(events));

//--- dv/cbts_bit_timing_tb.sv
// Self-checking bench for the bit timing block.
`timescale 1ns/1ps
`include "cbts_consts.svh"
module cbts_bit_timing_tb;
  import cbts_pkg::*;
  localparam int Q = 2; // Clocks per quantum for prescaler value two.
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, can_rx, rx_bit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  cbts_event_t events;
  int n_fail, checked, tmo;
  int n_rs = 0; // Re-synchronisation pulses seen on the event port.
  int n_hs = 0; // Hard synchronisation pulses seen on the event port.
  int dur[9] = '{10, 10, 10, 12, 10, 8, 10, 10, 10}; // Quanta per bit; late and early edges.
  logic [64:0] apb_q[$]; // Expected error flag, read mask and read word.
  logic bit_q[$]; // Expected levels at coming sample points.
  cbts_bit_timing i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .can_rx(can_rx), .rx_bit(rx_bit), .events(events));
  cbts_bus_node i_node (.pclk(pclk), .can_rx(can_rx));
  // Free-running clock of 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Pseudo-random step from a fixed start.
  function automatic logic [31:0] next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One APB transfer; the expectation is noted before the request goes out.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] x, input logic err);
    apb_q.push_back({err, m, x});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Sends the nine-bit pattern, optionally noting the levels to be sampled.
  task automatic frame(input bit note);
    for (int i = 0; i < 9; i++) if (note) bit_q.push_back(i[0]);
    for (int i = 0; i < 9; i++) i_node.drive(i[0], dur[i] * Q);
    i_node.drive(1'b1, 40 * Q);
  endtask
  // Takes the oldest note whenever a result appears and compares.
  always @(posedge pclk) begin
    logic [64:0] e;
    if (pready === 1'b1) begin
      e = apb_q.pop_front();
      check("apb data", prdata & e[63:32], e[31:0]);
      check("apb error", pslverr, e[64]);
    end
    if (events.sample_point === 1'b1 && bit_q.size() > 0) check("sample", rx_bit, bit_q.pop_front());
    if (events.resync === 1'b1) n_rs++;
    if (events.hard_sync === 1'b1) n_hs++;
  end
  // Cuts a hang short.
  always @(posedge pclk) begin
    tmo++;
    if (tmo == 6000) begin
      n_fail++;
      summarize();
    end
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    n_fail = 0;
    checked = 0;
    tmo = 0;
    lfsr = 32'hBCB02A77;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `CBTS_CFG_OFFSET, 0, '1, `CBTS_CFG_RESET, 0);
    apb(0, `CBTS_CTRL_OFFSET, 0, '1, 32'h0, 0);
    apb(0, 12'h00C, 0, '1, 32'h0, 1);
    apb(1, 12'h00C, '1, '1, 32'h0, 1);
    repeat (4) begin
      lfsr = next(lfsr);
      apb(1, `CBTS_CFG_OFFSET, lfsr, '1, 32'h0, 0);
      apb(0, `CBTS_CFG_OFFSET, 0, '1, lfsr & `CBTS_CFG_WMASK, 0);
    end
    $display("register test done");
    apb(1, `CBTS_CFG_OFFSET, 32'h00133001, '1, 32'h0, 0);
    apb(1, `CBTS_CTRL_OFFSET, 32'h7, '1, 32'h0, 0);
    frame(1);
    apb(0, `CBTS_STATUS_OFFSET, 0, 32'h00FFFF02, 32'h00020100, 0);
    check("samples left", bit_q.size(), 0);
    check("resync pulses", n_rs, 2);
    check("hard pulses", n_hs, 1);
    $display("sync test done");
    apb(1, `CBTS_CTRL_OFFSET, 32'h3, '1, 32'h0, 0);
    frame(0);
    frame(0);
    apb(0, `CBTS_STATUS_OFFSET, 0, 32'h00FFFF02, 32'h00020200, 0);
    check("hard pulses", n_hs, 2);
    $display("rearm test done");
    summarize();
  end
endmodule // cbts_bit_timing_tb
